//--- core/sdram_ctrl_consts.vh
// Constants for the two-bank SDRAM host controller: register map, pin codes, timing.
// Assumes a 50 MHz controller clock and a three-clock read latency in the device.
`ifndef SDRAM_CTRL_CONSTS_VH
`define SDRAM_CTRL_CONSTS_VH

// ==========================================================
// Register word indices (byte address = 4 * index)
`define REG_CMD     3'h0
`define REG_ADDR    3'h1
`define REG_MODE    3'h2
`define REG_STATUS  3'h3
`define REG_IDX     3'h4
`define REG_DATA    3'h5

// ==========================================================
// Software opcodes in the command register
`define OP_ACT      3'h0
`define OP_READ     3'h1
`define OP_WRITE    3'h2
`define OP_PRE      3'h3
`define OP_PRE_ALL  3'h4
`define OP_REFRESH  3'h5
`define OP_MODE_SET 3'h6
`define OP_HALT     3'h7

// ==========================================================
// Pin command codes {cs_n, ras_n, cas_n, we_n}
`define CMD_DESELECT     4'hF
`define CMD_ACT          4'h3
`define CMD_READ         4'h5
`define CMD_WRITE        4'h4
`define CMD_PRE          4'h2
`define CMD_AUTO_REFRESH 4'h1
`define CMD_MODE_SET     4'h0
`define CMD_BURST_HALT   4'h6

// ==========================================================
// Mode register layout and default
`define LAT_MSB       6
`define LAT_LSB       4
`define WRAP_BIT      3
`define LEN_MSB       2
`define LEN_LSB       0
`define LAT_THREE     3'h3
`define LEN_FULL_PAGE 3'h7
`define MODE_RESET    12'h033
`define A10_ALL_BANKS 12'h400

// ==========================================================
// Timing
`define CLK_PERIOD_NS 32'h14
`define T_POWERUP_NS  32'h186A0
`define T_RP_NS       32'h1E
`define T_RCD_NS      32'h1E
`define T_RAS_NS      32'h32
`define T_RC_NS       32'h50
`define T_RSC_CLK     32'h2
`define T_DPL_CLK     32'h2
`define REFRESH_COUNT 2'h2
`define CAS_LAT       10'h003
`define SYNC_STAGES   10'h002
`define T_POWERUP_CYC ((`T_POWERUP_NS + `CLK_PERIOD_NS - 32'h1) / `CLK_PERIOD_NS)
`define T_RP_CYC      ((`T_RP_NS + `CLK_PERIOD_NS - 32'h1) / `CLK_PERIOD_NS)
`define T_RCD_CYC     ((`T_RCD_NS + `CLK_PERIOD_NS - 32'h1) / `CLK_PERIOD_NS)
`define T_RAS_CYC     ((`T_RAS_NS + `CLK_PERIOD_NS - 32'h1) / `CLK_PERIOD_NS)
`define T_RC_CYC      ((`T_RC_NS + `CLK_PERIOD_NS - 32'h1) / `CLK_PERIOD_NS)

// ==========================================================
// Burst buffer
`define BUF_AW 8
`define DQ_W   16

`endif

//--- core/sdram_word_buffer.v
// Burst data buffer: one write port, one read port with registered read data.
// Assumes the owner never needs write-through; a read sees old data in the write cycle.
`timescale 1ns/1ps
module sdram_word_buffer #(
   parameter AW = 8,
   parameter DW = 16
) (
   input wire clk,
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [DW-1:0] wdata,
   input wire [AW-1:0] raddr,
   output reg [DW-1:0] rdata
);
   // ==========================================================
   // Storage
   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

//--- core/sdram_burst_host.v
// Host controller for a two-bank SDRAM: power-on init, mode set, bursts, precharge.
// Assumes software serialises commands over Avalon-MM; DQ is a split three-signal pin.
`timescale 1ns/1ps
`include "sdram_ctrl_consts.vh"

module sdram_burst_host #(
   parameter [31:0] POWERUP_CYCLES = `T_POWERUP_CYC,
   parameter AW = `BUF_AW,
   parameter DW = `DQ_W
) (
   input wire CLK_IN,
   input wire RESET_IN,
   input wire [2:0] AVS_ADDRESS_IN,
   input wire AVS_READ_IN,
   input wire AVS_WRITE_IN,
   input wire [31:0] AVS_WRITEDATA_IN,
   output wire [31:0] AVS_READDATA_OUT,
   output wire AVS_WAITREQUEST_OUT,
   output wire SD_CKE_OUT,
   output wire SD_CS_N_OUT,
   output wire SD_RAS_N_OUT,
   output wire SD_CAS_N_OUT,
   output wire SD_WE_N_OUT,
   output wire [11:0] SD_ADDR_OUT,
   output wire [1:0] SD_DQM_OUT,
   output wire [DW-1:0] SD_DQ_OUT,
   output wire SD_DQ_OE_OUT,
   input wire [DW-1:0] SD_DQ_IN
);
   // ==========================================================
   // States
   localparam [3:0] S_POWER = 4'h0;
   localparam [3:0] S_PALL = 4'h1;
   localparam [3:0] S_REF = 4'h2;
   localparam [3:0] S_MODE = 4'h3;
   localparam [3:0] S_WAIT = 4'h4;
   localparam [3:0] S_IDLE = 4'h5;
   localparam [3:0] S_READ = 4'h6;
   localparam [3:0] S_WRITE = 4'h7;
   localparam [9:0] CAP_DLY = `CAS_LAT + `SYNC_STAGES;

   // ==========================================================
   // Functions
   // Reserved length codes fall back to one word
   function [8:0] burst_beats;
      input [2:0] code;
      begin
         case (code)
            3'h0: burst_beats = 9'h001;
            3'h1: burst_beats = 9'h002;
            3'h2: burst_beats = 9'h004;
            3'h3: burst_beats = 9'h008;
            `LEN_FULL_PAGE: burst_beats = 9'h100;
            default: burst_beats = 9'h001;
         endcase
      end
   endfunction

   function [12:0] wait_load;
      input [31:0] cyc;
      reg [31:0] t;
      begin
         t = cyc - 32'h1;
         wait_load = t[12:0];
      end
   endfunction

   // ==========================================================
   // Declarations
   reg [3:0] state;
   reg [3:0] ret_state;
   reg [12:0] wait_cnt;
   reg [1:0] ref_cnt;
   reg [9:0] st;
   reg [8:0] beats;
   reg full_page;
   reg init_done;
   reg cmd_pending;
   reg [2:0] op;
   reg [11:0] addr_reg;
   reg [11:0] mode_reg;
   reg [11:0] dev_mode;
   reg [AW-1:0] idx;
   reg [12:0] ras_cnt0;
   reg [12:0] ras_cnt1;
   reg [12:0] dpl_cnt;
   reg open0;
   reg open1;
   reg [3:0] cmd;
   reg [11:0] pin_addr;
   reg [1:0] dqm;
   reg [DW-1:0] dq_out;
   reg dq_oe;
   reg [1:0] rd_stage;
   reg [31:0] readdata;
   reg [DW-1:0] dq_s1;
   reg [DW-1:0] dq_s2;
   wire busy;
   wire sel_cmd;
   wire sel_data;
   wire stall_w;
   wire rd_hold;
   wire av_wr;
   wire av_rd_done;
   wire cap_we;
   wire [9:0] cap_off;
   wire [AW-1:0] mem_raddr;
   wire [AW-1:0] mem_waddr;
   wire [DW-1:0] mem_wdata;
   wire mem_we;
   wire [DW-1:0] mem_rdata;
   wire pre_bank_ok;
   wire pre_all_ok;

   // ==========================================================
   // Avalon-MM slave
   assign busy = cmd_pending | ~init_done | (state != S_IDLE);
   assign sel_cmd = (AVS_ADDRESS_IN == `REG_CMD);
   assign sel_data = (AVS_ADDRESS_IN == `REG_DATA);
   // Commands and buffer traffic stall while the controller owns the buffer
   assign stall_w = AVS_WRITE_IN & (sel_cmd | sel_data) & busy;
   assign rd_hold = sel_data & busy;
   assign AVS_WAITREQUEST_OUT = stall_w | (AVS_READ_IN & (rd_stage != 2'h2));
   assign AVS_READDATA_OUT = readdata;
   assign av_wr = AVS_WRITE_IN & ~stall_w;
   assign av_rd_done = AVS_READ_IN & (rd_stage == 2'h2);

   always @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         op <= `OP_ACT;
         addr_reg <= 12'h000;
         mode_reg <= `MODE_RESET;
         idx <= {AW{1'b0}};
         rd_stage <= 2'h0;
         readdata <= 32'h00000000;
      end else begin
         if (av_wr) begin
            case (AVS_ADDRESS_IN)
               `REG_CMD: op <= AVS_WRITEDATA_IN[2:0];
               `REG_ADDR: addr_reg <= AVS_WRITEDATA_IN[11:0];
               `REG_MODE: mode_reg <= AVS_WRITEDATA_IN[11:0];
               `REG_IDX: idx <= AVS_WRITEDATA_IN[AW-1:0];
               `REG_DATA: idx <= idx + {{(AW-1){1'b0}}, 1'b1};
               default: idx <= idx;
            endcase
         end
         if (AVS_READ_IN & ~rd_hold & (rd_stage != 2'h2)) begin
            rd_stage <= rd_stage + 2'h1;
         end else begin
            rd_stage <= 2'h0;
         end
         if (rd_stage == 2'h1) begin
            case (AVS_ADDRESS_IN)
               `REG_CMD: readdata <= {29'h00000000, op};
               `REG_ADDR: readdata <= {20'h00000, addr_reg};
               `REG_MODE: readdata <= {20'h00000, mode_reg};
               `REG_STATUS: readdata <= {27'h0000000, cmd_pending, open1, open0, busy, init_done};
               `REG_IDX: readdata <= {{(32-AW){1'b0}}, idx};
               `REG_DATA: readdata <= {{(32-DW){1'b0}}, mem_rdata};
               default: readdata <= 32'h00000000;
            endcase
         end
         if (av_rd_done & sel_data) begin
            idx <= idx + {{(AW-1){1'b0}}, 1'b1};
         end
      end
   end

   // ==========================================================
   // Burst buffer
   assign cap_off = st - CAP_DLY;
   assign cap_we = (state == S_READ) & (st >= CAP_DLY) & (cap_off < {1'b0, beats});
   assign mem_we = cap_we | (av_wr & sel_data);
   assign mem_waddr = idx + (cap_we ? cap_off[AW-1:0] : {AW{1'b0}});
   assign mem_wdata = cap_we ? dq_s2 : AVS_WRITEDATA_IN[DW-1:0];
   // Write data are fetched two cycles ahead of the pins
   assign mem_raddr = idx + ((state == S_WRITE) ? st[AW-1:0] : {AW{1'b0}});

   sdram_word_buffer #(.AW(AW), .DW(DW)) u_buf (
      .clk(CLK_IN),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );

   // ==========================================================
   // Read data synchroniser
   always @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         dq_s1 <= {DW{1'b0}};
         dq_s2 <= {DW{1'b0}};
      end else begin
         dq_s1 <= SD_DQ_IN;
         dq_s2 <= dq_s1;
      end
   end

   // ==========================================================
   // Pins
   assign SD_CKE_OUT = 1'b1;
   assign SD_CS_N_OUT = cmd[3];
   assign SD_RAS_N_OUT = cmd[2];
   assign SD_CAS_N_OUT = cmd[1];
   assign SD_WE_N_OUT = cmd[0];
   assign SD_ADDR_OUT = pin_addr;
   assign SD_DQM_OUT = dqm;
   assign SD_DQ_OUT = dq_out;
   assign SD_DQ_OE_OUT = dq_oe;

   // A precharge also waits for the write-recovery counter
   assign pre_bank_ok = (addr_reg[11] ? (ras_cnt1 == 13'h0000) : (ras_cnt0 == 13'h0000))
      & (dpl_cnt == 13'h0000);
   assign pre_all_ok = (ras_cnt0 == 13'h0000) & (ras_cnt1 == 13'h0000) & (dpl_cnt == 13'h0000);

   // ==========================================================
   // Sequencer
   always @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         state <= S_POWER;
         ret_state <= S_POWER;
         wait_cnt <= 13'h0000;
         ref_cnt <= 2'h0;
         st <= 10'h000;
         beats <= 9'h001;
         full_page <= 1'b0;
         init_done <= 1'b0;
         cmd_pending <= 1'b0;
         dev_mode <= `MODE_RESET;
         ras_cnt0 <= 13'h0000;
         ras_cnt1 <= 13'h0000;
         dpl_cnt <= 13'h0000;
         open0 <= 1'b0;
         open1 <= 1'b0;
         cmd <= `CMD_DESELECT;
         pin_addr <= 12'h000;
         dqm <= 2'h3;
         dq_out <= {DW{1'b0}};
         dq_oe <= 1'b0;
      end else begin
         cmd <= `CMD_DESELECT;
         dq_oe <= 1'b0;
         dqm <= 2'h3;
         if (ras_cnt0 != 13'h0000) ras_cnt0 <= ras_cnt0 - 13'h0001;
         if (ras_cnt1 != 13'h0000) ras_cnt1 <= ras_cnt1 - 13'h0001;
         if (dpl_cnt != 13'h0000) dpl_cnt <= dpl_cnt - 13'h0001;
         if (av_wr & sel_cmd) begin
            cmd_pending <= 1'b1;
         end
         case (state)
            S_POWER: begin
               // Pins stay at deselect with masks high for the whole pause
               wait_cnt <= wait_load(POWERUP_CYCLES);
               ret_state <= S_PALL;
               state <= S_WAIT;
            end
            S_PALL: begin
               cmd <= `CMD_PRE;
               pin_addr <= `A10_ALL_BANKS;
               wait_cnt <= wait_load(`T_RP_CYC);
               ret_state <= S_REF;
               ref_cnt <= 2'h0;
               state <= S_WAIT;
            end
            S_REF: begin
               cmd <= `CMD_AUTO_REFRESH;
               ref_cnt <= ref_cnt + 2'h1;
               wait_cnt <= wait_load(`T_RC_CYC);
               ret_state <= (ref_cnt + 2'h1 >= `REFRESH_COUNT) ? S_MODE : S_REF;
               state <= S_WAIT;
            end
            S_MODE: begin
               cmd <= `CMD_MODE_SET;
               pin_addr <= mode_reg;
               dev_mode <= mode_reg;
               wait_cnt <= wait_load(`T_RSC_CLK);
               ret_state <= S_IDLE;
               state <= S_WAIT;
            end
            S_WAIT: begin
               if (wait_cnt == 13'h0000) begin
                  state <= ret_state;
               end else begin
                  wait_cnt <= wait_cnt - 13'h0001;
               end
            end
            S_IDLE: begin
               init_done <= 1'b1;
               if (cmd_pending) begin
                  st <= 10'h000;
                  beats <= burst_beats(dev_mode[`LEN_MSB:`LEN_LSB]);
                  full_page <= (dev_mode[`LEN_MSB:`LEN_LSB] == `LEN_FULL_PAGE);
                  ret_state <= S_IDLE;
                  case (op)
                     `OP_ACT: begin
                        cmd <= `CMD_ACT;
                        pin_addr <= addr_reg;
                        if (addr_reg[11]) begin
                           open1 <= 1'b1;
                           ras_cnt1 <= wait_load(`T_RAS_CYC);
                        end else begin
                           open0 <= 1'b1;
                           ras_cnt0 <= wait_load(`T_RAS_CYC);
                        end
                        wait_cnt <= wait_load(`T_RCD_CYC);
                        cmd_pending <= 1'b0;
                        state <= S_WAIT;
                     end
                     `OP_READ: begin
                        cmd <= `CMD_READ;
                        pin_addr <= {addr_reg[11], 1'b0, addr_reg[9:0]};
                        dqm <= 2'h0;
                        cmd_pending <= 1'b0;
                        state <= S_READ;
                     end
                     `OP_WRITE: begin
                        cmd_pending <= 1'b0;
                        state <= S_WRITE;
                     end
                     `OP_PRE: begin
                        if (pre_bank_ok) begin
                           cmd <= `CMD_PRE;
                           pin_addr <= {addr_reg[11], 11'h000};
                           if (addr_reg[11]) open1 <= 1'b0;
                           else open0 <= 1'b0;
                           wait_cnt <= wait_load(`T_RP_CYC);
                           cmd_pending <= 1'b0;
                           state <= S_WAIT;
                        end
                     end
                     `OP_PRE_ALL: begin
                        if (pre_all_ok) begin
                           cmd <= `CMD_PRE;
                           pin_addr <= `A10_ALL_BANKS;
                           open0 <= 1'b0;
                           open1 <= 1'b0;
                           wait_cnt <= wait_load(`T_RP_CYC);
                           cmd_pending <= 1'b0;
                           state <= S_WAIT;
                        end
                     end
                     `OP_REFRESH: begin
                        cmd <= `CMD_AUTO_REFRESH;
                        wait_cnt <= wait_load(`T_RC_CYC);
                        cmd_pending <= 1'b0;
                        state <= S_WAIT;
                     end
                     `OP_MODE_SET: begin
                        state <= S_MODE;
                        cmd_pending <= 1'b0;
                     end
                     `OP_HALT: begin
                        cmd <= `CMD_BURST_HALT;
                        cmd_pending <= 1'b0;
                     end
                     default: cmd_pending <= 1'b0;
                  endcase
               end
            end
            S_READ: begin
               // Capture runs latency plus synchroniser stages behind the command
               st <= st + 10'h001;
               if (st < `CAS_LAT + {1'b0, beats}) begin
                  dqm <= 2'h0;
               end
               // A full page never ends by itself; halt after the last wanted word
               if (full_page & (st == {1'b0, beats} - 10'h001)) begin
                  cmd <= `CMD_BURST_HALT;
               end
               // The bank is precharged only after the burst is fully done
               if (st == CAP_DLY + {1'b0, beats} - 10'h001) begin
                  state <= S_IDLE;
               end
            end
            S_WRITE: begin
               st <= st + 10'h001;
               // Masks went high after any earlier read, well over three clocks ago
               if ((st >= 10'h001) & (st <= {1'b0, beats})) begin
                  dq_out <= mem_rdata;
                  dq_oe <= 1'b1;
                  dqm <= 2'h0;
               end
               if (st == 10'h001) begin
                  cmd <= `CMD_WRITE;
                  pin_addr <= {addr_reg[11], 1'b0, addr_reg[9:0]};
               end
               if (st == {1'b0, beats} + 10'h001) begin
                  // Data leave the bus together with the halt, so none is taken
                  if (full_page) cmd <= `CMD_BURST_HALT;
                  dpl_cnt <= wait_load(`T_DPL_CLK);
                  state <= S_IDLE;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule

//--- tb/sdram_host_checker.sv
// Concurrent checks on the SDRAM pin side of the host controller.
// Assumes it is bound to the host top module and sees only its ports.
`timescale 1ns/1ps
`include "sdram_ctrl_consts.vh"
module sdram_host_checker #(
   parameter [31:0] POWERUP_CYCLES = 32'h14
) (
   input wire CLK_IN,
   input wire RESET_IN,
   input wire SD_CKE_OUT,
   input wire SD_CS_N_OUT,
   input wire SD_RAS_N_OUT,
   input wire SD_CAS_N_OUT,
   input wire SD_WE_N_OUT,
   input wire [11:0] SD_ADDR_OUT,
   input wire [1:0] SD_DQM_OUT,
   input wire SD_DQ_OE_OUT
);
   wire [3:0] cmd = {SD_CS_N_OUT, SD_RAS_N_OUT, SD_CAS_N_OUT, SD_WE_N_OUT};
   reg [31:0] pu_cnt;
   reg pre_seen;
   reg [1:0] ref_cnt;
   reg [3:0] act_age;
   // ==========================================================
   // Helpers
   // Activate age is bank-blind: fine for one open bank at a time
   always @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         pu_cnt <= 32'h0;
         pre_seen <= 1'b0;
         ref_cnt <= 2'h0;
         act_age <= 4'hF;
      end else begin
         if (pu_cnt < POWERUP_CYCLES)
            pu_cnt <= pu_cnt + 32'h1;
         if (cmd == `CMD_PRE)
            pre_seen <= 1'b1;
         if (cmd == `CMD_AUTO_REFRESH && ref_cnt != 2'h2)
            ref_cnt <= ref_cnt + 2'h1;
         if (cmd == `CMD_ACT)
            act_age <= 4'h1;
         else if (act_age != 4'hF)
            act_age <= act_age + 4'h1;
      end
   end
   // ==========================================================
   // Assertions
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (RESET_IN);
   power_pause_a: assert property ((pu_cnt < POWERUP_CYCLES) |->
      SD_CS_N_OUT && $stable(SD_ADDR_OUT)) else $error("pins moved in power pause");
   first_pre_a: assert property ((!pre_seen && !SD_CS_N_OUT) |->
      cmd == `CMD_PRE && SD_ADDR_OUT[10]) else $error("first command not precharge all");
   mode_gap_a: assert property ((cmd == `CMD_MODE_SET) |=> SD_CS_N_OUT)
      else $error("command right after mode set");
   two_refresh_a: assert property ((cmd == `CMD_ACT) |-> ref_cnt == 2'h2)
      else $error("activate before two refreshes");
   init_mask_a: assert property (!pre_seen |-> SD_CKE_OUT && SD_DQM_OUT == 2'h3)
      else $error("clock gate or masks low in init");
   ras_time_a: assert property ((cmd == `CMD_PRE && !SD_ADDR_OUT[10]) |-> act_age >= 4'h3)
      else $error("precharge too soon after activate");
   pre_mask_a: assert property ((cmd == `CMD_PRE) |->
      SD_DQM_OUT == 2'h3 && $past(SD_DQM_OUT) == 2'h3) else $error("precharge unmasked");
   write_gap_a: assert property ((cmd == `CMD_PRE) |-> !$past(SD_DQ_OE_OUT))
      else $error("precharge right after write data");
   write_word_a: assert property ((cmd == `CMD_WRITE) |->
      SD_DQ_OE_OUT && SD_DQM_OUT == 2'h0) else $error("write without first word");
   read_bus_a: assert property ((cmd == `CMD_READ) |-> (!SD_DQ_OE_OUT) [*4])
      else $error("bus driven into read data");
endmodule

//--- tb/sdram_dev_model.sv
// Behavioural two-bank SDRAM: mode register, wrap order, three-clock reads, masked writes.
// Assumes legal commands; row addresses are ignored, one row per bank.
`timescale 1ns/1ps
`include "sdram_ctrl_consts.vh"
module sdram_dev_model (
   input wire clk,
   input wire [3:0] cmd,
   input wire [11:0] addr,
   input wire [1:0] dqm,
   input wire [15:0] dq_wr,
   output wire [15:0] dq_rd
);
   reg [15:0] mem [0:511];
   reg [11:0] burst_mode_config = 12'h000;
   reg [16:0] p0 = 17'h0, p1 = 17'h0, p2 = 17'h0;
   reg [15:0] last = 16'h0;
   reg [8:0] rd_left = 9'h0, wr_left = 9'h0;
   reg [7:0] rd_s, rd_k, wr_s, wr_k;
   reg rd_b, wr_b;
   wire [2:0] len = burst_mode_config[2:0];
   wire [8:0] n = (len == 3'h7) ? 9'h100 : (len < 3'h4) ? (9'h1 << len) : 9'h1;
   // Released bus shows the inverse of the last word, never a held value
   assign dq_rd = p2[16] ? p2[15:0] : ~last;
   function [8:0] loc(input b, input [7:0] s, input [7:0] k);
      reg [7:0] m;
      begin
         m = n[7:0] - 8'h1;
         loc = {b, (burst_mode_config[3] && n != 9'h100) ? (s ^ k) : ((s & ~m) | ((s + k) & m))};
      end
   endfunction
   always @(posedge clk) begin
      if (cmd == `CMD_MODE_SET)
         burst_mode_config <= addr;
      if (cmd == `CMD_WRITE) begin
         wr_b <= addr[11];
         wr_s <= addr[7:0];
         wr_k <= 8'h1;
         wr_left <= n - 9'h1;
         if (dqm == 2'h0)
            mem[loc(addr[11], addr[7:0], 8'h0)] <= dq_wr;
      end else if (cmd == `CMD_BURST_HALT || cmd == `CMD_PRE || cmd == `CMD_READ) begin
         wr_left <= 9'h0;
      end else if (wr_left != 9'h0) begin
         if (dqm == 2'h0)
            mem[loc(wr_b, wr_s, wr_k)] <= dq_wr;
         wr_k <= wr_k + 8'h1;
         wr_left <= wr_left - 9'h1;
      end
      if (cmd == `CMD_READ) begin
         rd_b <= addr[11];
         rd_s <= addr[7:0];
         rd_k <= 8'h1;
         rd_left <= n - 9'h1;
         p0 <= {1'b1, mem[loc(addr[11], addr[7:0], 8'h0)]};
      end else if (rd_left != 9'h0 && cmd != `CMD_BURST_HALT && cmd != `CMD_PRE
                   && cmd != `CMD_WRITE) begin
         p0 <= {1'b1, mem[loc(rd_b, rd_s, rd_k)]};
         rd_k <= rd_k + 8'h1;
         rd_left <= rd_left - 9'h1;
      end else begin
         // Words in flight still drain, so a stop floats the bus one latency later
         p0 <= 17'h0;
         rd_left <= 9'h0;
      end
      p1 <= p0;
      p2 <= p1;
      if (p2[16])
         last <= p2[15:0];
   end
endmodule

//--- tb/tb_top.sv
// Self-checking bench: Avalon tasks drive the host, a device model answers on the pins.
// Assumes a short power pause parameter so the run stays brief.
`timescale 1ns/1ps
`include "sdram_ctrl_consts.vh"
module tb_top;
   logic CLK_IN = 1'b0, RESET_IN = 1'b1, AVS_READ_IN = 1'b0, AVS_WRITE_IN = 1'b0;
   logic [2:0] AVS_ADDRESS_IN = 3'h0;
   logic [31:0] AVS_WRITEDATA_IN = 32'h0, rdata;
   wire [31:0] AVS_READDATA_OUT;
   wire AVS_WAITREQUEST_OUT, SD_CKE_OUT, SD_CS_N_OUT, SD_RAS_N_OUT, SD_CAS_N_OUT;
   wire SD_WE_N_OUT, SD_DQ_OE_OUT;
   wire [11:0] SD_ADDR_OUT;
   wire [1:0] SD_DQM_OUT;
   wire [15:0] SD_DQ_OUT, SD_DQ_IN, dq_rd;
   int n_errors = 0, checks = 0;
   assign SD_DQ_IN = SD_DQ_OE_OUT ? SD_DQ_OUT : dq_rd;
   sdram_burst_host #(.POWERUP_CYCLES(32'h14)) i_dut (.CLK_IN, .RESET_IN, .AVS_ADDRESS_IN,
      .AVS_READ_IN, .AVS_WRITE_IN, .AVS_WRITEDATA_IN, .AVS_READDATA_OUT, .AVS_WAITREQUEST_OUT,
      .SD_CKE_OUT, .SD_CS_N_OUT, .SD_RAS_N_OUT, .SD_CAS_N_OUT, .SD_WE_N_OUT, .SD_ADDR_OUT,
      .SD_DQM_OUT, .SD_DQ_OUT, .SD_DQ_OE_OUT, .SD_DQ_IN);
   sdram_dev_model i_mem (.clk(CLK_IN), .cmd({SD_CS_N_OUT, SD_RAS_N_OUT, SD_CAS_N_OUT,
      SD_WE_N_OUT}), .addr(SD_ADDR_OUT), .dqm(SD_DQM_OUT), .dq_wr(SD_DQ_IN), .dq_rd(dq_rd));
   // ==========================================================
   // Tasks
   task chk(input [31:0] seen, input [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task av(input w, input [2:0] a, input [31:0] d);
      @(posedge CLK_IN);
      AVS_WRITE_IN <= w;
      AVS_READ_IN <= !w;
      AVS_ADDRESS_IN <= a;
      AVS_WRITEDATA_IN <= d;
      do @(posedge CLK_IN); while (AVS_WAITREQUEST_OUT !== 1'b0);
      rdata = AVS_READDATA_OUT;
      AVS_WRITE_IN <= 1'b0;
      AVS_READ_IN <= 1'b0;
   endtask
   // Polls status until neither pending nor busy; the watchdog bounds it
   task cmd(input [2:0] op, input [11:0] a);
      av(1'b1, `REG_ADDR, {20'h0, a});
      av(1'b1, `REG_CMD, {29'h0, op});
      do av(1'b0, `REG_STATUS, 32'h0); while ((rdata[4] | rdata[1]) !== 1'b0);
   endtask
   function [8:0] eloc(input b, input [7:0] s, input [8:0] n, input w, input [7:0] k);
      reg [7:0] m;
      begin
         m = n[7:0] - 8'h1;
         eloc = {b, w ? (s ^ k) : ((s & ~m) | ((s + k) & m))};
      end
   endfunction
   // Case 8 is the sequential full-page burst
   task run_case(input int i);
      logic [7:0] s;
      logic [8:0] n;
      logic [2:0] c;
      logic w, b;
      w = i[2];
      b = i[0];
      c = i[3] ? `LEN_FULL_PAGE : {1'b0, i[1:0]};
      n = i[3] ? 9'h100 : 9'h1 << i[1:0];
      s = 8'h41 + 8'(i * 37);
      av(1'b1, `REG_MODE, {20'h0, 5'h0, `LAT_THREE, w, c});
      cmd(`OP_MODE_SET, 12'h0);
      cmd(`OP_ACT, {b, 11'h123});
      chk(rdata[b ? 3 : 2], 1'b1);
      av(1'b1, `REG_IDX, 32'h0);
      for (int k = 0; k < n; k++) av(1'b1, `REG_DATA, 32'hA000 + i * 16 + k);
      // Each data write moved the index, so point it back at the first word
      av(1'b1, `REG_IDX, 32'h0);
      cmd(`OP_WRITE, {b, 3'h0, s});
      for (int k = 0; k < n; k++) chk(i_mem.mem[eloc(b, s, n, w, 8'(k))], 32'hA000 + i * 16 + k);
      av(1'b1, `REG_IDX, 32'h80);
      cmd(`OP_READ, {b, 3'h0, s});
      av(1'b1, `REG_IDX, 32'h80);
      for (int k = 0; k < n; k++) begin
         av(1'b0, `REG_DATA, 32'h0);
         chk(rdata[15:0], 32'hA000 + i * 16 + k);
      end
      cmd(`OP_PRE, {b, 11'h0});
      chk(rdata[b ? 3 : 2], 1'b0);
      $display("case %0d done, errors %0d", i, n_errors);
   endtask
   task conclude;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========================================================
   // Clock, watchdog, main sequence
   initial begin
      forever #10 CLK_IN = ~CLK_IN;
   end
   initial begin
      repeat (60000) @(posedge CLK_IN);
      n_errors++;
      conclude;
   end
   initial begin
      repeat (3) @(posedge CLK_IN);
      RESET_IN <= 1'b0;
      av(1'b0, `REG_MODE, 32'h0);
      chk(rdata[11:0], `MODE_RESET);
      av(1'b1, 3'h7, 32'hFFFF_FFFF);
      av(1'b0, 3'h7, 32'h0);
      chk(rdata, 32'h0);
      do av(1'b0, `REG_STATUS, 32'h0); while (rdata[0] !== 1'b1);
      for (int i = 0; i < 9; i++) run_case(i);
      cmd(`OP_ACT, 12'h800);
      chk(rdata[3], 1'b1);
      cmd(`OP_PRE_ALL, 12'h000);
      chk(rdata[3:2], 2'h0);
      cmd(`OP_REFRESH, 12'h000);
      cmd(`OP_HALT, 12'h000);
      chk(rdata[4:1], 4'h0);
      $display("command case done, errors %0d", n_errors);
      conclude;
   end
endmodule
bind sdram_burst_host sdram_host_checker #(.POWERUP_CYCLES(POWERUP_CYCLES)) i_chk (.CLK_IN,
   .RESET_IN, .SD_CKE_OUT, .SD_CS_N_OUT, .SD_RAS_N_OUT, .SD_CAS_N_OUT, .SD_WE_N_OUT,
   .SD_ADDR_OUT, .SD_DQM_OUT, .SD_DQ_OE_OUT);
